//--- hdl/isc_consts.svh
// constants for the inline storage crypto control block
`ifndef ISC_CONSTS_SVH
`define ISC_CONSTS_SVH
// register offsets (byte addresses)
`define ISC_REG_STATUS   8'h00
`define ISC_REG_IRQ_STAT 8'h04
`define ISC_REG_IRQ_MASK 8'h08
`define ISC_REG_DKEY0    8'h10
// dkey words 0..15 at 8'h10..8'h4C (two 256-bit halves)
`define ISC_DKEY_WORDS   16
// flag codes in the mode/algorithm word
`define ISC_FLAG_NONE    2'h0
`define ISC_FLAG_CBC     2'h1
`define ISC_FLAG_XTS     2'h2
// mode_algorithm_word field positions
`define ISC_DISK_LSB     0
`define ISC_FILE_LSB     2
`define ISC_KLEN_BIT     4
// status register bits
`define ISC_ST_PASS      0
`define ISC_ST_FAIL      1
`define ISC_ST_BUSY      2
// irq bits
`define ISC_IRQ_DONE     0
`define ISC_IRQ_REJ      1
`define ISC_IRQ_STERR    2
`define ISC_IRQ_W        3
// self-test duration
`define ISC_SELFTEST_NS  100
`define ISC_CLK_NS       5
`define ISC_SELFTEST_CYC ((`ISC_SELFTEST_NS + `ISC_CLK_NS - 1) / `ISC_CLK_NS)
`endif

//--- hdl/isc_pkg.sv
// types of the inline storage crypto control block
package isc_pkg;
   typedef enum logic [2:0]
   {
      ISC_SELFTEST = 3'h0,
      ISC_IDLE     = 3'h1,
      ISC_CHECK    = 3'h3,
      ISC_RUN      = 3'h2,
      ISC_ERROR    = 3'h6
   } isc_state_type;
endpackage

//--- hdl/isc_key_check.sv
// key-halves comparator for xts requests
`timescale 1ns/10ps
`default_nettype none
module isc_key_check
(
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic [255:0] keyA,
   input  wire logic [255:0] keyB,
   input  wire logic         keyLong,
   output logic              keysEqual
);
   typedef struct packed
   {
      logic eq;
   } isc_kc_type;
   isc_kc_type s_q;
   isc_kc_type s_d;

   // short keys compare only the low 128 bits of each half
   always_comb
   begin
      s_d = s_q;
      if (keyLong)
         s_d.eq = (keyA == keyB);
      else
         s_d.eq = (keyA[127:0] == keyB[127:0]);
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign keysEqual = s_q.eq;
endmodule // isc_key_check
`default_nettype wire

//--- hdl/isc_ctrl.sv
// control and gating of the inline storage crypto engine
//
// Overview of operation
// - self-test starts by itself after reset, no software action
// - passing self-test enters approved state automatically; no other mode
// - failed self-test sets global error flag and enters error state
// - error state refuses every encrypt and decrypt request
// - status shows pass in approved state, fail in error state
// - cbc mode with 128 or 256 bit keys
// - xts mode with 128 or 256 bit keys
// - xts key halves compared before use: disk halves when disk layer is xts, else file halves
// - no bypass: selected data never leaves unprocessed
// - disk and file flags of the mode/algorithm word both decoded
// - nonzero flag means all plaintext entering is encrypted
// - both flags zero: no function, no plaintext enters the block
// - disk layer xts only; file layer cbc or xts; both allowed
// - every request from descriptor input returns success or fail
`timescale 1ns/10ps
`default_nettype none
`include "isc_consts.svh"
module isc_ctrl
   import isc_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         nrst,
   // register port
   input  wire logic [7:0]   regAddr,
   input  wire logic [31:0]  regWdata,
   input  wire logic         regWr,
   input  wire logic         regRd,
   output logic [31:0]       regRdata,
   output logic              irq,
   // self-test engine
   output logic              selfTestStart,
   input  wire logic         selfTestDone,
   input  wire logic         selfTestPass,
   // descriptor request
   input  wire logic         reqValid,
   output logic              reqReady,
   input  wire logic [4:0]   modeAlgorithmWord,
   input  wire logic [255:0] fileKey,
   input  wire logic [255:0] fileTweakKey,
   // answer
   output logic              respValid,
   output logic              respOk,
   // cipher core steering
   output logic              coreRun,
   output logic [1:0]        coreDiskMode,
   output logic [1:0]        coreFileMode,
   output logic              coreKeyLong,
   input  wire logic         coreDone,
   // data path gate
   output logic              dataEnable
);
   ////////////////////////////////////////////////////////////////////////
   localparam int STW = 8;
   localparam logic [STW-1:0] ST_CYC = STW'(`ISC_SELFTEST_CYC);

   typedef struct packed
   {
      isc_state_type          st;
      logic [STW-1:0]         wait_;
      logic                   started;
      logic                   errFlag;
      logic [1:0]             disk;
      logic [1:0]             file;
      logic                   klen;
      logic                   respV;
      logic                   respOk;
      logic [`ISC_IRQ_W-1:0]  iStat;
      logic [`ISC_IRQ_W-1:0]  iMask;
      logic [31:0]            rdata;
      logic [`ISC_DKEY_WORDS*32-1:0] dkey;
   } isc_ctrl_type;

   isc_ctrl_type s_q;
   isc_ctrl_type s_d;
   logic         stDone1_q, stDone2_q, stPass1_q, stPass2_q;
   logic         keysEqual;
   logic [255:0] cmpA, cmpB;

   // index of a disk key word, or all ones when not a key address
   function automatic logic [4:0] keyIndex(input logic [7:0] a);
      logic [7:0] off;
      off = a - `ISC_REG_DKEY0;
      if (a >= `ISC_REG_DKEY0 && off[1:0] == 2'h0
          && off[7:2] < 6'(`ISC_DKEY_WORDS))
         keyIndex = {1'b0, off[5:2]};
      else
         keyIndex = 5'h1F;
   endfunction

   // a flag code is legal for the layer it belongs to
   function automatic logic flagLegal(input logic [1:0] f,
                                      input logic       isDisk);
      flagLegal = (f == `ISC_FLAG_NONE) || (f == `ISC_FLAG_XTS)
                  || (!isDisk && f == `ISC_FLAG_CBC);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // self-test result may come from another domain: two-stage sync
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         stDone1_q <= 1'b0;
         stDone2_q <= 1'b0;
         stPass1_q <= 1'b0;
         stPass2_q <= 1'b0;
      end
      else
      begin
         stDone1_q <= selfTestDone;
         stDone2_q <= stDone1_q;
         stPass1_q <= selfTestPass;
         stPass2_q <= stPass1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // xts key halves: disk layer uses the disk key register, else file keys
   always_comb
   begin
      if (s_q.disk == `ISC_FLAG_XTS)
      begin
         cmpA = s_q.dkey[255:0];
         cmpB = s_q.dkey[511:256];
      end
      else
      begin
         cmpA = fileKey;
         cmpB = fileTweakKey;
      end
   end

   isc_key_check u_keyCheck
   (
      .clk       (clk),
      .nrst      (nrst),
      .keyA      (cmpA),
      .keyB      (cmpB),
      .keyLong   (s_q.klen),
      .keysEqual (keysEqual)
   );

   ////////////////////////////////////////////////////////////////////////
   logic [`ISC_IRQ_W-1:0] evt;
   logic [4:0]            ki;
   logic                  xtsAny;
   logic                  equalBad;

   always_comb
   begin
      s_d      = s_q;
      evt      = '0;
      ki       = keyIndex(regAddr);
      s_d.respV = 1'b0;
      xtsAny   = (s_q.disk == `ISC_FLAG_XTS) || (s_q.file == `ISC_FLAG_XTS);
      // the key comparator only matters when either layer is xts
      equalBad = keysEqual && xtsAny;
      unique case (s_q.st)
         ISC_SELFTEST:
         begin
            s_d.started = 1'b1;
            if (s_q.wait_ != '0)
               s_d.wait_ = s_q.wait_ - 1'b1;
            else if (stDone2_q)
            begin
               if (stPass2_q)
                  s_d.st = ISC_IDLE;
               else
               begin
                  s_d.st      = ISC_ERROR;
                  s_d.errFlag = 1'b1;
                  evt[`ISC_IRQ_STERR] = 1'b1;
               end
            end
         end
         ISC_IDLE:
         begin
            if (reqValid)
            begin
               s_d.disk = modeAlgorithmWord[`ISC_DISK_LSB +: 2];
               s_d.file = modeAlgorithmWord[`ISC_FILE_LSB +: 2];
               s_d.klen = modeAlgorithmWord[`ISC_KLEN_BIT];
               s_d.st   = ISC_CHECK;
            end
         end
         ISC_CHECK:
         begin
            // comparator result is one cycle behind the latched flags
            if (s_q.wait_ == '0)
               s_d.wait_ = STW'(1);
            else
            begin
               s_d.wait_ = '0;
               if (!flagLegal(s_q.disk, 1'b1)
                   || !flagLegal(s_q.file, 1'b0) || equalBad)
               begin
                  s_d.st     = ISC_IDLE;
                  s_d.respV  = 1'b1;
                  s_d.respOk = 1'b0;
                  evt[`ISC_IRQ_REJ] = 1'b1;
               end
               else if (s_q.disk == `ISC_FLAG_NONE
                        && s_q.file == `ISC_FLAG_NONE)
               begin
                  // nothing requested: no data is admitted
                  s_d.st     = ISC_IDLE;
                  s_d.respV  = 1'b1;
                  s_d.respOk = 1'b1;
                  evt[`ISC_IRQ_DONE] = 1'b1;
               end
               else
                  s_d.st = ISC_RUN;
            end
         end
         ISC_RUN:
         begin
            if (coreDone)
            begin
               s_d.st     = ISC_IDLE;
               s_d.respV  = 1'b1;
               s_d.respOk = 1'b1;
               evt[`ISC_IRQ_DONE] = 1'b1;
            end
         end
         ISC_ERROR:
         begin
            // left only by reset
            s_d.st = ISC_ERROR;
            if (reqValid)
            begin
               s_d.respV  = 1'b1;
               s_d.respOk = 1'b0;
               evt[`ISC_IRQ_REJ] = 1'b1;
            end
         end
         default:
            s_d.st = ISC_ERROR;
      endcase

      // register writes
      if (regWr)
      begin
         if (regAddr == `ISC_REG_IRQ_MASK)
            s_d.iMask = regWdata[`ISC_IRQ_W-1:0];
         if (ki != 5'h1F)
            s_d.dkey[ki[3:0]*32 +: 32] = regWdata;
      end
      // set wins over write-one-to-clear
      if (regWr && regAddr == `ISC_REG_IRQ_STAT)
         s_d.iStat = (s_q.iStat & ~regWdata[`ISC_IRQ_W-1:0]) | evt;
      else
         s_d.iStat = s_q.iStat | evt;

      // reads answer one cycle later; key words never read back
      s_d.rdata = 32'h0;
      if (regRd)
      begin
         unique case (regAddr)
            `ISC_REG_STATUS:
            begin
               s_d.rdata[`ISC_ST_PASS] = (s_q.st != ISC_SELFTEST)
                                         && !s_q.errFlag;
               s_d.rdata[`ISC_ST_FAIL] = s_q.errFlag;
               s_d.rdata[`ISC_ST_BUSY] = (s_q.st == ISC_CHECK)
                                         || (s_q.st == ISC_RUN);
            end
            `ISC_REG_IRQ_STAT: s_d.rdata[`ISC_IRQ_W-1:0] = s_q.iStat;
            `ISC_REG_IRQ_MASK: s_d.rdata[`ISC_IRQ_W-1:0] = s_q.iMask;
            default:           s_d.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_q       <= '0;
         s_q.st    <= ISC_SELFTEST;
         s_q.wait_ <= ST_CYC;
      end
      else
         s_q <= s_d;
   end

   ////////////////////////////////////////////////////////////////////////
   assign regRdata      = s_q.rdata;
   assign irq           = |(s_q.iStat & s_q.iMask);
   assign selfTestStart = (s_q.st == ISC_SELFTEST) && !s_q.started;
   assign reqReady      = (s_q.st == ISC_IDLE) || (s_q.st == ISC_ERROR);
   assign respValid     = s_q.respV;
   assign respOk        = s_q.respOk;
   assign coreRun       = (s_q.st == ISC_RUN);
   assign coreDiskMode  = s_q.disk;
   assign coreFileMode  = s_q.file;
   assign coreKeyLong   = s_q.klen;
   // data admitted only into the core, never around it
   assign dataEnable    = (s_q.st == ISC_RUN);
endmodule // isc_ctrl
`default_nettype wire

//--- test/isc_ctrl_sva.sv
// port assertions of the crypto control block
`timescale 1ns/10ps
`default_nettype none
module isc_ctrl_sva
(
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        regRd,
   input wire logic [31:0] regRdata,
   input wire logic        selfTestStart,
   input wire logic        reqValid,
   input wire logic        reqReady,
   input wire logic [4:0]  modeAlgorithmWord,
   input wire logic        respValid,
   input wire logic        respOk,
   input wire logic        coreRun,
   input wire logic [1:0]  coreDiskMode,
   input wire logic [1:0]  coreFileMode,
   input wire logic        coreDone,
   input wire logic        dataEnable
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   wire logic take = reqValid && reqReady;
   // disk cbc, disk code 3 and file code 3 are all refused
   wire logic bad = take && (modeAlgorithmWord[0] ||
      &modeAlgorithmWord[3:2]);
   ////////////////////////////////////////
   AST_START: assert property ($rose(nrst) |-> selfTestStart)
      else $error("self-test not started");
   AST_ONCE: assert property (selfTestStart |=> !selfTestStart)
      else $error("self-test start held");
   AST_GATE: assert property (dataEnable == coreRun &&
      (!coreRun || (coreDiskMode | coreFileMode) != 2'h0))
      else $error("data gate differs from run");
   AST_END: assert property (coreRun && coreDone |=>
      respValid && respOk && !coreRun)
      else $error("run end without success answer");
   AST_HOLD: assert property (coreRun && !coreDone |=> coreRun)
      else $error("run dropped early");
   AST_NONE: assert property (take &&
      modeAlgorithmWord[3:0] == 4'h0 |=> !coreRun [*4])
      else $error("run without function");
   AST_BAD: assert property (bad |=>
      (!coreRun && !(respValid && respOk)) [*4])
      else $error("illegal flags accepted");
   AST_MODE: assert property ($rose(coreRun) |->
      !coreDiskMode[0] && coreFileMode != 2'h3 &&
      (coreDiskMode | coreFileMode) != 2'h0)
      else $error("run with illegal modes");
   AST_ANSWER: assert property (take |=>
      ##[0:2] (respValid || coreRun))
      else $error("request not answered");
   AST_PULSE: assert property (respValid |=> !respValid)
      else $error("answer longer than a cycle");
   AST_RDATA: assert property (!regRd |=> regRdata == 32'h0)
      else $error("read data outside read slot");
   cover property (take && modeAlgorithmWord[3:0] == 4'h0);
   cover property ($rose(coreRun));
   cover property (respValid && !respOk);
endmodule // isc_ctrl_sva
bind isc_ctrl isc_ctrl_sva u_sva (.clk(clk), .nrst(nrst), .regRd(regRd),
   .regRdata(regRdata), .selfTestStart(selfTestStart),
   .reqValid(reqValid), .reqReady(reqReady),
   .modeAlgorithmWord(modeAlgorithmWord), .respValid(respValid),
   .respOk(respOk), .coreRun(coreRun), .coreDiskMode(coreDiskMode),
   .coreFileMode(coreFileMode), .coreDone(coreDone),
   .dataEnable(dataEnable));
`default_nettype wire

//--- test/isc_far_model.sv
// self-test engine and cipher core answering the control block
`timescale 1ns/10ps
`default_nettype none
module isc_far_model
(
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       passCfg,
   input  wire logic [3:0] lag,
   input  wire logic       selfTestStart,
   output logic            selfTestDone,
   output logic            selfTestPass,
   input  wire logic       coreRun,
   output logic            coreDone
);
   logic [3:0] stCnt_q, runCnt_q;
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         stCnt_q      <= 4'h0;
         runCnt_q     <= 4'h0;
         selfTestDone <= 1'b0;
      end
      else
      begin
         if (selfTestStart || stCnt_q != 4'h0)
            stCnt_q <= stCnt_q + 4'h1;
         if (stCnt_q == 4'h7)
            selfTestDone <= 1'b1;
         runCnt_q <= coreRun ? runCnt_q + 4'h1 : 4'h0;
      end
   end
   // verdict line is meaningless before done, so it shows the wrong one
   assign selfTestPass = selfTestDone ? passCfg : ~passCfg;
   assign coreDone = coreRun && runCnt_q == lag;
endmodule // isc_far_model
`default_nettype wire

//--- test/tb_isc_ctrl.sv
// self-checking bench of the crypto control block
`timescale 1ns/10ps
`default_nettype none
module tb_isc_ctrl;
   logic         clk, nrst, regWr, regRd, irq, selfTestStart, selfTestDone;
   logic         selfTestPass, reqValid, reqReady, respValid, respOk;
   logic         coreRun, coreKeyLong, coreDone, dataEnable, passCfg;
   logic [7:0]   regAddr;
   logic [31:0]  regWdata, regRdata, rdv, lfsr;
   logic [4:0]   modeAlgorithmWord, w;
   logic [1:0]   coreDiskMode, coreFileMode, e;
   logic [255:0] fileKey, fileTweakKey, diskA, diskB, fk, tk;
   logic [3:0]   lag;
   int           err_count, num_checks, k;
   logic [4:0]   corner [7] = '{5'h00, 5'h08, 5'h1A, 5'h04, 5'h01,
                                5'h0C, 5'h03};
   isc_ctrl u_dut (.clk(clk), .nrst(nrst), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .irq(irq), .selfTestStart(selfTestStart),
      .selfTestDone(selfTestDone), .selfTestPass(selfTestPass),
      .reqValid(reqValid), .reqReady(reqReady),
      .modeAlgorithmWord(modeAlgorithmWord), .fileKey(fileKey),
      .fileTweakKey(fileTweakKey), .respValid(respValid),
      .respOk(respOk), .coreRun(coreRun), .coreDiskMode(coreDiskMode),
      .coreFileMode(coreFileMode), .coreKeyLong(coreKeyLong),
      .coreDone(coreDone), .dataEnable(dataEnable));
   isc_far_model u_far (.clk(clk), .nrst(nrst), .passCfg(passCfg),
      .lag(lag), .selfTestStart(selfTestStart),
      .selfTestDone(selfTestDone), .selfTestPass(selfTestPass),
      .coreRun(coreRun), .coreDone(coreDone));
   ////////////////////////////////////////
   task automatic check(string s, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task automatic summarize();
      if (err_count == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   function automatic logic [31:0] nxt(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic draw(output logic [255:0] v);
      for (int i = 0; i < 8; i++)
      begin
         lfsr = nxt(lfsr);
         v[32 * i +: 32] = lfsr;
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(logic [7:0] a);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 rdv = regRdata;
      @(posedge clk);
   endtask
   task automatic loadkey();
      for (int i = 0; i < 16; i++)
         wr(8'(8'h10 + 4 * i), i < 8 ? diskA[32 * i +: 32] :
            diskB[32 * (i - 8) +: 32]);
   endtask
   task automatic boot(logic p, logic [31:0] st);
      passCfg <= p;
      nrst <= 1'b0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      rdv = 32'h0;
      for (int n = 0; n < 40 && rdv[1:0] == 2'h0; n++)
         rd(8'h00);
      check("status", rdv, st);
   endtask
   // bit 0 success, bit 1 cipher run
   function automatic logic [1:0] exp_req(logic [4:0] d, logic [255:0] a,
      logic [255:0] b);
      if (d[3:0] == 4'h0)
         return 2'b01;
      if (d[0] || d[3:2] == 2'h3)
         return 2'b00;
      if (d[1])
      begin
         a = diskA;
         b = diskB;
      end
      if (!d[4])
      begin
         a[255:128] = 128'h0;
         b[255:128] = 128'h0;
      end
      return ((d[1] || d[3]) && a == b) ? 2'b00 : 2'b11;
   endfunction
   task automatic req(logic [4:0] d, logic expOk, logic expRun);
      logic got, ran;
      got = 1'b0;
      ran = 1'b0;
      modeAlgorithmWord <= d;
      reqValid <= 1'b1;
      @(posedge clk);
      reqValid <= 1'b0;
      for (int n = 0; n < 60 && !got; n++)
      begin
         #1;
         if (coreRun === 1'b1 && !ran)
         begin
            ran = 1'b1;
            check("disk", coreDiskMode, d[1:0]);
            check("file", coreFileMode, d[3:2]);
            check("klen", coreKeyLong, d[4]);
            check("gate", dataEnable, 1'b1);
            check("busy", reqReady, 1'b0);
         end
         got = respValid === 1'b1;
         if (got)
            check("ready", reqReady, 1'b1);
         @(posedge clk);
      end
      check("answer", got, 1'b1);
      check("ok", respOk, expOk);
      check("ran", ran, expRun);
   endtask
   ////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial
   begin
      #100000;
      err_count++;
      summarize();
   end
   initial
   begin
      {nrst, regWr, regRd, reqValid, passCfg, lag, regAddr} = 17'h0;
      {fileKey, fileTweakKey, regWdata, modeAlgorithmWord} = '0;
      lfsr = 32'hB876;
      boot(1'b1, 32'h1);
      rd(8'hFC);
      check("unmapped", rdv, 32'h0);
      draw(diskA);
      draw(diskB);
      loadkey();
      rd(8'h10);
      check("key read", rdv, 32'h0);
      for (k = 0; k < 30; k++)
      begin
         draw(fk);
         draw(tk);
         w = (k < 7) ? corner[k] : lfsr[4:0];
         // equal low halves only differ in outcome by key length
         if (lfsr[7])
            tk[127:0] = fk[127:0];
         if (lfsr[7] && lfsr[9])
            tk = fk;
         lag <= lfsr[11:8];
         fileKey <= fk;
         fileTweakKey <= tk;
         e = exp_req(w, fk, tk);
         req(w, e[0], e[1]);
      end
      diskB[127:0] = diskA[127:0];
      loadkey();
      req(5'h02, 1'b0, 1'b0);
      req(5'h12, 1'b1, 1'b1);
      rd(8'h04);
      check("irq stat", rdv, 32'h3);
      wr(8'h08, 32'h0);
      check("irq off", irq, 1'b0);
      wr(8'h08, 32'h3);
      check("irq on", irq, 1'b1);
      wr(8'h04, 32'h1);
      wr(8'h08, 32'h1);
      check("irq mask", irq, 1'b0);
      wr(8'h04, 32'h2);
      rd(8'h04);
      check("irq clr", rdv, 32'h0);
      boot(1'b0, 32'h2);
      rd(8'h04);
      check("st err", rdv, 32'h4);
      req(5'h08, 1'b0, 1'b0);
      req(5'h00, 1'b0, 1'b0);
      rd(8'h00);
      check("err held", rdv, 32'h2);
      boot(1'b1, 32'h1);
      summarize();
   end
endmodule // tb_isc_ctrl
`default_nettype wire
